/* File: inc/autofill_pkg.sv */
package autofill_pkg;

  localparam int unsigned LVL_W        = 16;
  localparam int unsigned FRAC_W       = 4;
  localparam int unsigned ACC_W        = LVL_W + FRAC_W;
  localparam int unsigned MIN_PRESC_W  = 30;
  localparam int unsigned DAMP_PRESC_W = 14;

  // timing base
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned CLK_NS       = 1_000_000_000 / CLK_HZ;
  localparam int unsigned MINUTE_S     = 60;
  localparam int unsigned MINUTE_CYC   = MINUTE_S * CLK_HZ;

  // damping: period is five time constants, filter gain is 2**-FRAC_W per step
  localparam int unsigned DAMP_TAUS     = 5;
  localparam int unsigned DAMP_UNIT_NS  = 100_000_000;
  localparam int unsigned DAMP_STEP_NS  = DAMP_UNIT_NS / (DAMP_TAUS * (2 ** FRAC_W));
  localparam int unsigned DAMP_STEP_CYC = DAMP_STEP_NS / CLK_NS;

  typedef enum logic [2:0]
  {
    MODE_AUTO_OFF  = 3'h0,
    MODE_AUTO_ON   = 3'h1,
    MODE_M_OPEN    = 3'h2,
    MODE_M_CLOSED  = 3'h3,
    MODE_M_PRECOOL = 3'h4
  } mode_t;

  typedef enum logic [1:0]
  {
    PH_IDLE    = 2'h0,
    PH_PRECOOL = 2'h1,
    PH_FILL    = 2'h2,
    PH_TIMEOUT = 2'h3
  } phase_t;

  typedef struct packed {
    logic [LVL_W-1:0] start_lvl;
    logic [LVL_W-1:0] stop_lvl;
    logic [15:0]      precool_min;
    logic [15:0]      timeout_min;
    logic [15:0]      damp_ds;
  } cfg_t;

  typedef struct packed {
    logic precool;
    logic filling;
    logic timeout;
  } stat_t;

  localparam mode_t RST_MODE = MODE_AUTO_OFF;
  localparam cfg_t  RST_CFG  = '0;

endpackage

/* File: core/autofill_ctrl.sv */
// Contract
// - precool vents, fill closed, configured minutes
// - fill timer starts at fill; expiry alarms
// - zero fill timeout never raises alarm
// - settings and state apply only on save
// - reset and setup leave autofill disabled
// - auto-on keeps level between setpoints
// - auto fill open too long: alarm, stop
// - manual open fills, precool first if nonzero
// - level alarm in manual open closes all
// - manual closed shuts both valves always
// - disabled state does no fill control
// - manual precool runs, then manual open
// - report precool, filling, timeout indications
// - save clears alarm; auto-on restarts fill
// - first-order damping, period five time constants
// - zero damping passes raw level through
// - damped level drives indication and control
`timescale 1ns/1ps
`default_nettype none

module autofill_ctrl
  import autofill_pkg::*;
#(
  parameter int unsigned MIN_CYC  = MINUTE_CYC,
  parameter int unsigned STEP_CYC = DAMP_STEP_CYC
)
(
  input  wire  logic             i_clk,
  input  wire  logic             i_sys_rst,
  input  wire  logic [LVL_W-1:0] i_level,
  input  wire  logic             i_alarm_ge,
  input  wire  mode_t            i_pend_mode,
  input  wire  cfg_t             i_pend_cfg,
  input  wire  logic             i_save,
  output var   logic             o_vent,
  output var   logic             o_fill,
  output var   logic [LVL_W-1:0] o_level,
  output var   mode_t            o_mode,
  output var   stat_t            o_stat
);

  typedef struct packed {
    mode_t                   mode;
    phase_t                  phase;
    cfg_t                    cfg;
    logic [MIN_PRESC_W-1:0]  min_presc;
    logic [15:0]             min_cnt;
    logic [DAMP_PRESC_W-1:0] damp_presc;
    logic [15:0]             damp_cnt;
    logic [ACC_W-1:0]        acc;
    logic [LVL_W-1:0]        level;
    logic                    vent;
    logic                    fill;
    stat_t                   stat;
  } state_t;

  localparam state_t RST_STATE = '{
    mode:       RST_MODE,
    phase:      PH_IDLE,
    cfg:        RST_CFG,
    min_presc:  '0,
    min_cnt:    '0,
    damp_presc: '0,
    damp_cnt:   '0,
    acc:        '0,
    level:      '0,
    vent:       1'b0,
    fill:       1'b0,
    stat:       '0
  };

  state_t r;
  state_t next_r;

  logic              min_tick;
  logic              step_tick;
  logic              restart;
  logic              precool_done;
  logic signed [ACC_W:0] diff;
  phase_t            first_phase;

  always_comb
  begin
    next_r       = r;
    restart      = 1'b0;
    diff         = $signed({1'b0, i_level, {FRAC_W{1'b0}}}) - $signed({1'b0, r.acc});
    step_tick    = (r.damp_presc == DAMP_PRESC_W'(STEP_CYC - 1));
    min_tick     = (r.min_presc == MIN_PRESC_W'(MIN_CYC - 1));
    precool_done = (r.min_cnt >= r.cfg.precool_min);
    first_phase  = (r.cfg.precool_min == 16'h0000) ? PH_FILL : PH_PRECOOL;

    // damping filter; the stepped update trades exactness for no divider
    if (r.cfg.damp_ds == 16'h0000)
    begin
      next_r.acc        = {i_level, {FRAC_W{1'b0}}};
      next_r.damp_presc = '0;
      next_r.damp_cnt   = '0;
    end
    else
    begin
      next_r.damp_presc = step_tick ? '0 : r.damp_presc + 1'b1;
      if (step_tick)
      begin
        if (r.damp_cnt + 16'h0001 >= r.cfg.damp_ds)
        begin
          next_r.damp_cnt = '0;
          next_r.acc      = r.acc + ACC_W'(diff >>> FRAC_W);
        end
        else
        begin
          next_r.damp_cnt = r.damp_cnt + 16'h0001;
        end
      end
    end
    next_r.level = next_r.acc[ACC_W-1:FRAC_W];

    // minute timebase
    next_r.min_presc = min_tick ? '0 : r.min_presc + 1'b1;
    if (min_tick && r.min_cnt != 16'hFFFF)
    begin
      next_r.min_cnt = r.min_cnt + 16'h0001;
    end

    if (i_save)
    begin
      // saving also clears a standing timeout
      next_r.mode = i_pend_mode;
      next_r.cfg  = i_pend_cfg;
      restart     = 1'b1;
      if ((i_pend_mode == MODE_M_OPEN) || (i_pend_mode == MODE_M_PRECOOL))
      begin
        next_r.phase = (i_pend_cfg.precool_min == 16'h0000) ? PH_FILL : PH_PRECOOL;
      end
      else
      begin
        next_r.phase = PH_IDLE;
      end
    end
    else
    begin
      unique case (r.mode)
        MODE_AUTO_ON:
        begin
          unique case (r.phase)
            PH_IDLE:
            begin
              if (r.level <= r.cfg.start_lvl)
              begin
                next_r.phase = first_phase;
                restart      = 1'b1;
              end
            end
            PH_PRECOOL:
            begin
              if (precool_done)
              begin
                next_r.phase = PH_FILL;
                restart      = 1'b1;
              end
            end
            PH_FILL:
            begin
              if (r.level >= r.cfg.stop_lvl)
              begin
                next_r.phase = PH_IDLE;
              end
              else if ((r.cfg.timeout_min != 16'h0000) &&
                       (r.min_cnt >= r.cfg.timeout_min))
              begin
                next_r.phase = PH_TIMEOUT;
              end
            end
            PH_TIMEOUT:
            begin
              next_r.phase = PH_TIMEOUT;
            end
          endcase
        end
        MODE_M_OPEN:
        begin
          if (i_alarm_ge)
          begin
            next_r.mode  = MODE_M_CLOSED;
            next_r.phase = PH_IDLE;
          end
          else if (r.phase != PH_FILL && precool_done)
          begin
            next_r.phase = PH_FILL;
            restart      = 1'b1;
          end
        end
        MODE_M_PRECOOL:
        begin
          if (r.phase != PH_PRECOOL || precool_done)
          begin
            next_r.mode  = MODE_M_OPEN;
            next_r.phase = PH_FILL;
            restart      = 1'b1;
          end
        end
        MODE_M_CLOSED, MODE_AUTO_OFF:
        begin
          next_r.phase = PH_IDLE;
        end
        default:
        begin
          next_r.mode  = MODE_AUTO_OFF;
          next_r.phase = PH_IDLE;
        end
      endcase
    end

    if (restart)
    begin
      next_r.min_presc = '0;
      next_r.min_cnt   = '0;
    end

    next_r.vent         = (next_r.phase == PH_PRECOOL);
    next_r.fill         = (next_r.phase == PH_FILL);
    next_r.stat.precool = next_r.vent;
    next_r.stat.filling = next_r.fill;
    next_r.stat.timeout = (next_r.phase == PH_TIMEOUT);
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      r <= RST_STATE;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign o_vent  = r.vent;
  assign o_fill  = r.fill;
  assign o_level = r.level;
  assign o_mode  = r.mode;
  assign o_stat  = r.stat;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  valve_excl_a: assert property (!(o_vent && o_fill))
    else $error("vent and fill open together");
  precool_vent_a: assert property (o_stat.precool |-> o_vent && !o_fill)
    else $error("precool without venting only");
  timeout_stops_a: assert property (o_stat.timeout |-> !o_fill && !o_vent)
    else $error("valve open during timeout");
  zero_timeout_a: assert property ((r.cfg.timeout_min == 16'h0000) && !o_stat.timeout
                                   |=> !o_stat.timeout)
    else $error("timeout raised with zero limit");
  save_applies_a: assert property (i_save |=> o_mode == $past(i_pend_mode))
    else $error("saved state not applied");
  save_clears_a: assert property (i_save |=> !o_stat.timeout)
    else $error("save left timeout set");
  closed_off_a: assert property ((o_mode == MODE_M_CLOSED || o_mode == MODE_AUTO_OFF)
                                 |-> !o_vent && !o_fill)
    else $error("valve open in closed or disabled");
  alarm_close_a: assert property ((o_mode == MODE_M_OPEN) && i_alarm_ge && !i_save
                                  |=> (o_mode == MODE_M_CLOSED) && !o_fill && !o_vent)
    else $error("level alarm did not close valves");
  damp_bypass_a: assert property ((r.cfg.damp_ds == 16'h0000) && !i_save
                                  |=> o_level == $past(i_level))
    else $error("bypass level differs from raw");
  auto_start_a: assert property ((o_mode == MODE_AUTO_ON) && (r.phase == PH_IDLE) &&
                                 (o_level <= r.cfg.start_lvl) && !i_save
                                 |=> o_vent || o_fill)
    else $error("auto fill did not start");
  auto_stop_a: assert property ((o_mode == MODE_AUTO_ON) && o_fill &&
                                (o_level >= r.cfg.stop_lvl) && !i_save
                                |=> !o_fill)
    else $error("auto fill did not stop");


  // indications are copies of the valve flops, so they can never disagree
  vent_ind_a: assert property (o_stat.precool == o_vent)
    else $error("precool indication differs from vent");

  fill_ind_a: assert property (o_stat.filling == o_fill)
    else $error("filling indication differs from fill");

  auto_off_idle_a: assert property ((o_mode == MODE_AUTO_OFF) && !i_save
                                    |=> !o_vent && !o_fill)
    else $error("disabled state moved a valve");

  closed_stays_a: assert property ((o_mode == MODE_M_CLOSED) && !i_save
                                   |=> (o_mode == MODE_M_CLOSED))
    else $error("manual closed left without save");

  timeout_hold_a: assert property (o_stat.timeout && !i_save
                                   |=> o_stat.timeout)
    else $error("timeout cleared without save");

  // manual states carry no fill timer, so the alarm belongs to auto-on only
  manual_no_to_a: assert property ((o_mode != MODE_AUTO_ON)
                                   |-> !o_stat.timeout)
    else $error("timeout outside auto-on");

  precool_end_a: assert property ((o_mode == MODE_AUTO_ON) && o_vent && !i_save &&
                                  (r.min_cnt >= r.cfg.precool_min) |=> o_fill)
    else $error("fill did not follow precool");

  fill_timer_a: assert property ($rose(o_fill)
                                 |-> (r.min_cnt == 16'h0000))
    else $error("fill timer not restarted");

  mprecool_open_a: assert property ((o_mode == MODE_M_PRECOOL) && o_vent && !i_save &&
                                    (r.min_cnt >= r.cfg.precool_min)
                                    |=> (o_mode == MODE_M_OPEN) && o_fill)
    else $error("manual precool did not open");

  timeout_trip_a: assert property ((o_mode == MODE_AUTO_ON) && o_fill && !i_save &&
                                   (r.cfg.timeout_min != 16'h0000) &&
                                   (r.min_cnt >= r.cfg.timeout_min) &&
                                   (o_level < r.cfg.stop_lvl) |=> o_stat.timeout)
    else $error("fill timeout not raised");

  // illegal codes only reach the flops through a save of a bad selection
  bad_mode_a: assert property ((o_mode > MODE_M_PRECOOL) && !i_save
                               |=> (o_mode == MODE_AUTO_OFF))
    else $error("illegal state not dropped");

  mopen_fill_a: assert property ((o_mode == MODE_M_OPEN) && !o_vent && !i_alarm_ge &&
                                 !i_save |=> o_fill)
    else $error("manual open not filling");

  timeout_seen_c: cover property (o_fill ##1 o_stat.timeout);
  precool_fill_c: cover property (o_vent ##1 o_fill);
  mprecool_open_c: cover property ((o_mode == MODE_M_PRECOOL) ##1 (o_mode == MODE_M_OPEN));
  alarm_close_c: cover property ((o_mode == MODE_M_OPEN) ##1 (o_mode == MODE_M_CLOSED));
  auto_stop_c: cover property ((o_mode == MODE_AUTO_ON) && o_fill ##1 !o_fill);

endmodule

`default_nettype wire

/* File: dv/vessel_model.sv */
`timescale 1ns/1ps
`default_nettype none
module vessel_model
  import autofill_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_fill,
  input  wire logic             i_flow,
  input  wire logic             i_load,
  input  wire logic [LVL_W-1:0] i_load_lvl,
  input  wire logic [LVL_W-1:0] i_alarm_lvl,
  output var  logic [LVL_W-1:0] o_level,
  output var  logic             o_alarm_ge
);
  logic [2:0] boil = 3'h0;
  // slow boil-off drags the level down one count every eight cycles, stopping at zero
  always_ff @(posedge i_clk)
  begin
    boil <= boil + 3'h1;
    if (i_load)
      o_level <= i_load_lvl;
    else if (i_fill && i_flow)
      o_level <= o_level + 16'h0001;
    else if (boil == 3'h0 && o_level != 16'h0000)
      o_level <= o_level - 16'h0001;
  end
  // flow off models an empty source, so an open fill valve gains nothing
  assign o_alarm_ge = (o_level >= i_alarm_lvl);
endmodule
`default_nettype wire

/* File: dv/precooled_autofill_controller_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module precooled_autofill_controller_bench
  import autofill_pkg::*;
;
  localparam int unsigned MC = 20;
  typedef struct packed {
    mode_t       mode;
    logic [15:0] pc;
    mode_t       xmode;
    logic        xvent;
    logic        xfill;
  } row_t;
  logic             i_clk     = 1'b0;
  logic             i_sys_rst = 1'b1;
  logic             i_save    = 1'b0;
  mode_t            pmode     = MODE_AUTO_OFF;
  cfg_t             cfg       = '0;
  cfg_t             c;
  logic             flow      = 1'b0;
  logic             load      = 1'b1;
  logic [LVL_W-1:0] load_lvl  = '0;
  logic [LVL_W-1:0] alarm_lvl = 16'hFFFF;
  logic [LVL_W-1:0] level;
  logic [LVL_W-1:0] o_level;
  logic [LVL_W-1:0] lvl_last;
  logic             alarm_ge;
  logic             o_vent;
  logic             o_fill;
  mode_t            o_mode;
  stat_t            o_stat;
  int               bad_count  = 0;
  int               n_compared = 0;
  int               cyc        = 0;
  int               n;
  row_t             rows [6];

  autofill_ctrl #(.MIN_CYC(MC), .STEP_CYC(2)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_level(level), .i_alarm_ge(alarm_ge), .i_pend_mode(pmode), .i_pend_cfg(cfg),
    .i_save(i_save), .o_vent(o_vent), .o_fill(o_fill), .o_level(o_level), .o_mode(o_mode),
    .o_stat(o_stat));
  vessel_model tank (.i_clk(i_clk), .i_fill(o_fill), .i_flow(flow), .i_load(load),
    .i_load_lvl(load_lvl), .i_alarm_lvl(alarm_lvl), .o_level(level), .o_alarm_ge(alarm_ge));

  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) lvl_last <= level;
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      bad_count = bad_count + 1;
      results();
    end
  end

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // indications must mirror the valves, so one packed word checks all
  task automatic cst(input mode_t m, input logic v, input logic f, input logic t);
    chk("state", {8'h00, m, v, f, t, v, f}, {8'h00, o_mode, o_stat, o_vent, o_fill});
  endtask
  task automatic save(input mode_t m, input cfg_t k);
    @(posedge i_clk);
    pmode  <= m;
    cfg    <= k;
    i_save <= 1'b1;
    @(posedge i_clk);
    i_save <= 1'b0;
  endtask
  task automatic setlvl(input logic [15:0] v, input logic f);
    @(posedge i_clk);
    load     <= 1'b1;
    load_lvl <= v;
    flow     <= f;
    @(posedge i_clk);
    load <= 1'b0;
  endtask
  task automatic wait_for(input int sel, input logic v, input int lim);
    n = 0;
    while (((sel == 0) ? o_vent : (sel == 1) ? o_fill : o_stat.timeout) !== v && n < lim)
    begin
      @(negedge i_clk);
      n++;
    end
    chk("wait", 16'h0001, 16'(n < lim));
  endtask

  initial
  begin
    rows[0] = '{MODE_M_OPEN, 16'h0000, MODE_M_OPEN, 1'b0, 1'b1};
    rows[1] = '{MODE_M_CLOSED, 16'h0000, MODE_M_CLOSED, 1'b0, 1'b0};
    rows[2] = '{MODE_M_PRECOOL, 16'h0000, MODE_M_OPEN, 1'b0, 1'b1};
    rows[3] = '{MODE_AUTO_OFF, 16'h0000, MODE_AUTO_OFF, 1'b0, 1'b0};
    rows[4] = '{MODE_M_PRECOOL, 16'h0005, MODE_M_PRECOOL, 1'b1, 1'b0};
    rows[5] = '{mode_t'(3'h5), 16'h0000, MODE_AUTO_OFF, 1'b0, 1'b0};
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    load      <= 1'b0;
    @(negedge i_clk);
    cst(MODE_AUTO_OFF, 1'b0, 1'b0, 1'b0);
    @(posedge i_clk);
    pmode <= MODE_M_OPEN;
    repeat (4) @(negedge i_clk);
    cst(MODE_AUTO_OFF, 1'b0, 1'b0, 1'b0);
    c = '0;
    foreach (rows[i])
    begin
      c.precool_min = rows[i].pc;
      save(rows[i].mode, c);
      repeat (2) @(negedge i_clk);
      cst(rows[i].xmode, rows[i].xvent, rows[i].xfill, 1'b0);
    end
    c.precool_min = 16'h0002;
    save(MODE_M_OPEN, c);
    repeat (5) @(negedge i_clk);
    cst(MODE_M_OPEN, 1'b1, 1'b0, 1'b0);
    wait_for(1, 1'b1, 200);
    chk("precool_len", 16'h0001, 16'(n + 5 >= 2 * MC - 1 && n + 5 <= 2 * MC + 3));
    @(posedge i_clk);
    alarm_lvl <= 16'h0000;
    repeat (2) @(negedge i_clk);
    cst(MODE_M_CLOSED, 1'b0, 1'b0, 1'b0);
    @(posedge i_clk);
    alarm_lvl <= 16'hFFFF;
    c = '0;
    c.start_lvl = 16'h0064;
    c.stop_lvl = 16'h0082;
    c.precool_min = 16'h0001;
    setlvl(16'h0078, 1'b1);
    save(MODE_AUTO_ON, c);
    wait_for(0, 1'b1, 400);
    chk("start_lvl", 16'h0001, 16'(o_level <= 16'h0064));
    cst(MODE_AUTO_ON, 1'b1, 1'b0, 1'b0);
    wait_for(1, 1'b1, 100);
    cst(MODE_AUTO_ON, 1'b0, 1'b1, 1'b0);
    wait_for(1, 1'b0, 200);
    chk("stop_lvl", 16'h0001, 16'(o_level >= 16'h0082));
    c.precool_min = 16'h0000;
    c.timeout_min = 16'h0001;
    setlvl(16'h0032, 1'b0);
    save(MODE_AUTO_ON, c);
    wait_for(1, 1'b1, 10);
    wait_for(2, 1'b1, 100);
    chk("timeout_len", 16'h0001, 16'(n >= MC - 2 && n <= MC + 2));
    cst(MODE_AUTO_ON, 1'b0, 1'b0, 1'b1);
    save(MODE_AUTO_ON, c);
    repeat (2) @(negedge i_clk);
    cst(MODE_AUTO_ON, 1'b0, 1'b1, 1'b0);
    wait_for(2, 1'b1, 100);
    save(MODE_M_CLOSED, c);
    repeat (2) @(negedge i_clk);
    cst(MODE_M_CLOSED, 1'b0, 1'b0, 1'b0);
    c.timeout_min = 16'h0000;
    save(MODE_AUTO_ON, c);
    repeat (3 * MC) @(negedge i_clk);
    cst(MODE_AUTO_ON, 1'b0, 1'b1, 1'b0);
    c = '0;
    save(MODE_AUTO_OFF, c);
    setlvl(16'h03E8, 1'b0);
    repeat (3) @(negedge i_clk);
    chk("raw_level", lvl_last, o_level);
    c.damp_ds = 16'h0001;
    save(MODE_AUTO_OFF, c);
    setlvl(16'h0000, 1'b0);
    repeat (10) @(negedge i_clk);
    chk("damp_slow", 16'h0001, 16'(o_level >= 16'h0100));
    repeat (160) @(negedge i_clk);
    chk("damped", 16'h0001, 16'(o_level <= 16'h0010));
    save(MODE_M_OPEN, c);
    repeat (2) @(negedge i_clk);
    cst(MODE_M_OPEN, 1'b0, 1'b1, 1'b0);
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    @(negedge i_clk);
    cst(MODE_AUTO_OFF, 1'b0, 1'b0, 1'b0);
    chk("rst_level", 16'h0000, o_level);
    @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (2) @(negedge i_clk);
    cst(MODE_AUTO_OFF, 1'b0, 1'b0, 1'b0);
    results();
  end
endmodule
`default_nettype wire
